// File: inc/crrbs_pkg.sv
// Constants and types for the clock-ratio, reset-indication and boot strap logic
package crrbs_pkg;

  // ==========================================================================
  // Reset-indication timing
  localparam int         LOCK_W      = 12;
  localparam logic [11:0] LOCK_CYCLES = 12'hFF0;  // 4080 input-clock cycles

  // ==========================================================================
  // Core multiplier values and reserved core-ratio code
  localparam logic [3:0] MULT_NONE = 4'h0;  // Reserved ratio code
  localparam logic [3:0] MULT_X2   = 4'h2;
  localparam logic [3:0] MULT_X3   = 4'h3;
  localparam logic [3:0] MULT_X4   = 4'h4;
  localparam logic [3:0] MULT_X6   = 4'h6;
  localparam logic [3:0] MULT_X8   = 4'h8;
  localparam logic [1:0] RATIO_RSVD = 2'h3; // Unassigned core-ratio code

  // ==========================================================================
  // Boot DMA channels
  localparam logic [3:0] DMA_CH_NONE   = 4'h0;
  localparam logic [3:0] DMA_CH_SERIAL = 4'h8;  // SPI and link boot
  localparam logic [3:0] DMA_CH_EXTPRT = 4'hA;  // Host and EPROM boot

  // ==========================================================================
  // Fetch start address after reset, plain default
  localparam int          ADDR_W       = 24;
  localparam logic [23:0] RESET_VECTOR = 24'h000000;

  // ==========================================================================
  // Pin synchroniser width and reset values
  localparam int          SYNC_W     = 13;
  localparam logic [12:0] SYNC_RST   = 13'h0000;
  localparam logic [2:0]  ID_KEEPER  = 3'h0;  // Identity 00x, low bit ignored

  // ==========================================================================
  // Boot modes, one-hot
  typedef enum logic [5:0] {
    CRRBS_BOOT_EPROM = 6'h01,
    CRRBS_BOOT_HOST  = 6'h02,
    CRRBS_BOOT_SPI   = 6'h04,
    CRRBS_BOOT_LINK  = 6'h08,
    CRRBS_BOOT_NONE  = 6'h10,
    CRRBS_BOOT_RSVD  = 6'h20
  } crrbs_boot_t;

endpackage

// File: inc/crrbs_lock_if.sv
// Carrier between the strap controller and its lock timer
`timescale 1ns/1ps
interface crrbs_lock_if;
  logic                      hold;    // Timer held cleared while reset stands
  logic                      locked;  // Lock period has elapsed
  logic [crrbs_pkg::LOCK_W-1:0] count;  // Cycles since reset release

  modport timer (input hold, output locked, output count);
  modport ctrl  (output hold, input locked, input count);
endinterface

// File: hw/crrbs_lock_timer.sv
// Counter that times the multiplier lock period after reset release
`timescale 1ns/1ps
module crrbs_lock_timer (
  input wire logic clk,          // Input clock
  input wire logic srst,         // Synchronous reset, active high
  crrbs_lock_if.timer lk         // Hold in, lock state out
);

  // ==========================================================================
  // Lock counter
  // counts release cycles
  always_ff @(posedge clk) begin
    if (srst || lk.hold) begin
      lk.count <= '0;
    end else if (lk.count != crrbs_pkg::LOCK_CYCLES) begin
      lk.count <= lk.count + 12'h001;
    end
  end

  // Locked rises one edge early so the top's output flop lands on edge 4080
  always_ff @(posedge clk) begin
    if (srst || lk.hold) begin
      lk.locked <= 1'b0;
    end else if (lk.count == crrbs_pkg::LOCK_CYCLES - 12'h002) begin
      lk.locked <= 1'b1;
    end
  end

  // ==========================================================================
  // Checks
  count_bound_a: assert property (@(posedge clk) disable iff (srst)
    lk.count <= crrbs_pkg::LOCK_CYCLES)
    else $error("lock counter ran past its limit");

  lock_point_a: assert property (@(posedge clk) disable iff (srst)
    $rose(lk.locked) |-> lk.count == crrbs_pkg::LOCK_CYCLES - 12'h001)
    else $error("lock flag rose at the wrong count");

endmodule

// File: hw/crrbs_strap_ctrl.sv
// Clock-ratio, reset-indication and boot strap controller
`timescale 1ns/1ps
module crrbs_strap_ctrl (
  input  wire logic        clk,                      // Input clock, 20 MHz
  input  wire logic        srst,                     // Device reset, sync, high
  input  wire logic        clock_double_select,      // Strap, low enables doubling
  input  wire logic [1:0]  core_ratio_select,        // Core ratio strap
  input  wire logic        eprom_boot_strap,         // EPROM boot strap
  input  wire logic        link_boot_strap,          // Link boot strap
  input  wire logic [2:0]  processor_identity_strap, // Identity strap
  input  wire logic        bus_master,               // Pin, high while bus master
  input  wire logic        host_bus_grant_n,         // Pin, low when host owns bus
  input  wire logic        boot_memory_select_in,    // Boot select pin level
  input  wire logic        eprom_select,             // Loader wants EPROM selected
  output logic [3:0]       core_multiplier,          // Core to input clock ratio
  output logic             ratio_reserved,           // Ratio code 11 sampled
  output logic             port_clock_double,        // Port clock at 2x
  output logic             port_clock_output,        // Port clock pin level
  output logic             port_clock_output_oe_n,   // Low while pin is driven
  output logic             port_clock_keeper_en,     // Keeper latch enable
  output logic             reset_indication_out_n,   // Low while core in reset
  output logic             core_fetch_en,            // Core may fetch
  output logic [23:0]      fetch_address,            // First fetch address
  output logic [5:0]       boot_mode,                // One-hot boot mode
  output logic [3:0]       boot_dma_channel,         // DMA channel for boot
  output logic             boot_reserved,            // Both boot straps high
  output logic             boot_memory_select_out,   // Chip select, low active
  output logic             boot_memory_select_oe_n   // Low while pin is driven
);

  // ==========================================================================
  // Pin synchronisers
  logic [12:0] sync1_reg;
  logic [12:0] sync2_reg;
  logic [12:0] pins;

  assign pins = {clock_double_select, core_ratio_select, eprom_boot_strap, link_boot_strap,
                 processor_identity_strap, bus_master, host_bus_grant_n,
                 boot_memory_select_in, 2'b00};

  // Two flops before any logic reads a pin; no reset, so straps pass while reset stands
  always_ff @(posedge clk) begin
    sync1_reg <= pins;
    sync2_reg <= sync1_reg;
  end

  logic       dbl_s;
  logic [1:0] ratio_s;
  logic       eprom_boot_strap_s;
  logic       link_boot_strap_s;
  logic [2:0] id_s;
  logic       master_s;
  logic       hbg_n_s;
  logic       bms_s;

  assign dbl_s    = sync2_reg[12];
  assign ratio_s  = sync2_reg[11:10];
  assign eprom_boot_strap_s  = sync2_reg[9];
  assign link_boot_strap_s  = sync2_reg[8];
  assign id_s     = sync2_reg[7:5];
  assign master_s = sync2_reg[4];
  assign hbg_n_s  = sync2_reg[3];
  assign bms_s    = sync2_reg[2];

  // ==========================================================================
  // Strap capture
  logic       dbl_reg;
  logic [1:0] ratio_reg;
  logic       eprom_boot_strap_reg;
  logic       link_boot_strap_reg;
  logic [2:0] id_reg;
  logic       bms_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      dbl_reg   <= dbl_s;
      ratio_reg <= ratio_s;
      eprom_boot_strap_reg <= eprom_boot_strap_s;
      link_boot_strap_reg <= link_boot_strap_s;
      id_reg    <= id_s;
      bms_reg   <= bms_s;
    end
  end

  // ==========================================================================
  // Clock ratio decode
  logic [3:0] mult_next;

  always_comb begin
    case (ratio_reg)
      2'h0:    mult_next = dbl_reg ? crrbs_pkg::MULT_X2 : crrbs_pkg::MULT_X4;
      2'h1:    mult_next = dbl_reg ? crrbs_pkg::MULT_X3 : crrbs_pkg::MULT_X6;
      2'h2:    mult_next = dbl_reg ? crrbs_pkg::MULT_X4 : crrbs_pkg::MULT_X8;
      default: mult_next = crrbs_pkg::MULT_NONE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      core_multiplier   <= crrbs_pkg::MULT_NONE;
      ratio_reserved    <= 1'b0;
      port_clock_double <= 1'b0;
    end else begin
      core_multiplier   <= mult_next;
      ratio_reserved    <= (ratio_reg == crrbs_pkg::RATIO_RSVD);
      port_clock_double <= ~dbl_reg;
    end
  end

  // ==========================================================================
  // Port clock output; clk stands for four times the input clock rate
  logic pclk_div_reg;
  logic owns_bus;

  assign owns_bus = master_s & hbg_n_s;

  always_ff @(posedge clk) begin
    if (srst) begin
      pclk_div_reg <= 1'b0;
    end else begin
      pclk_div_reg <= ~pclk_div_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      port_clock_output <= 1'b0;
    end else if (owns_bus && (port_clock_double || pclk_div_reg)) begin
      port_clock_output <= ~port_clock_output;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      port_clock_output_oe_n <= 1'b1;
    end else begin
      port_clock_output_oe_n <= ~owns_bus;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      port_clock_keeper_en <= 1'b0;
    end else begin
      port_clock_keeper_en <= (id_reg[2:1] == crrbs_pkg::ID_KEEPER[2:1]);
    end
  end

  // ==========================================================================
  // Reset indication and fetch start
  crrbs_lock_if lk ();

  assign lk.hold = srst;

  crrbs_lock_timer u_timer (
    .clk  (clk),
    .srst (srst),
    .lk   (lk)
  );

  always_ff @(posedge clk) begin
    if (srst) begin
      reset_indication_out_n <= 1'b0;
      core_fetch_en          <= 1'b0;
      fetch_address          <= crrbs_pkg::RESET_VECTOR;
    end else begin
      reset_indication_out_n <= lk.locked;
      core_fetch_en          <= lk.locked;
      fetch_address          <= crrbs_pkg::RESET_VECTOR;
    end
  end

  // ==========================================================================
  // Boot mode decode
  crrbs_pkg::crrbs_boot_t mode_next;
  logic [3:0]             chan_next;

  always_comb begin
    case ({eprom_boot_strap_reg, link_boot_strap_reg})
      2'b10:   mode_next = crrbs_pkg::CRRBS_BOOT_EPROM;
      2'b00:   mode_next = bms_reg ? crrbs_pkg::CRRBS_BOOT_HOST : crrbs_pkg::CRRBS_BOOT_NONE;
      2'b01:   mode_next = bms_reg ? crrbs_pkg::CRRBS_BOOT_LINK : crrbs_pkg::CRRBS_BOOT_SPI;
      default: mode_next = crrbs_pkg::CRRBS_BOOT_RSVD;
    endcase
  end

  always_comb begin
    case (mode_next)
      crrbs_pkg::CRRBS_BOOT_EPROM: chan_next = crrbs_pkg::DMA_CH_EXTPRT;
      crrbs_pkg::CRRBS_BOOT_HOST:  chan_next = crrbs_pkg::DMA_CH_EXTPRT;
      crrbs_pkg::CRRBS_BOOT_SPI:   chan_next = crrbs_pkg::DMA_CH_SERIAL;
      crrbs_pkg::CRRBS_BOOT_LINK:  chan_next = crrbs_pkg::DMA_CH_SERIAL;
      default:                     chan_next = crrbs_pkg::DMA_CH_NONE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      boot_mode        <= crrbs_pkg::CRRBS_BOOT_NONE;
      boot_dma_channel <= crrbs_pkg::DMA_CH_NONE;
      boot_reserved    <= 1'b0;
    end else begin
      boot_mode        <= mode_next;
      boot_dma_channel <= chan_next;
      boot_reserved    <= (mode_next == crrbs_pkg::CRRBS_BOOT_RSVD);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      boot_memory_select_out  <= 1'b1;
      boot_memory_select_oe_n <= 1'b1;
    end else begin
      boot_memory_select_out  <= ~eprom_select;
      boot_memory_select_oe_n <= ~((mode_next == crrbs_pkg::CRRBS_BOOT_EPROM) && owns_bus);
    end
  end

  // ==========================================================================
  // Checks
  oe_follows_bus_a: assert property (@(posedge clk) disable iff (srst)
    !port_clock_output_oe_n |-> $past(owns_bus))
    else $error("port clock driven without bus ownership");

  no_toggle_float_a: assert property (@(posedge clk) disable iff (srst)
    $changed(port_clock_output) |-> $past(owns_bus))
    else $error("port clock toggled while not owning the bus");

  single_rate_a: assert property (@(posedge clk) disable iff (srst)
    (!port_clock_double && owns_bus && $past(owns_bus) && $changed(port_clock_output))
    |=> !$changed(port_clock_output))
    else $error("port clock ran fast in single mode");

  ratio_table_a: assert property (@(posedge clk) disable iff (srst)
    (!dbl_reg && ratio_reg == 2'h2) |=> core_multiplier == crrbs_pkg::MULT_X8)
    else $error("doubled code 10 did not give 8x");

  straps_frozen_a: assert property (@(posedge clk) disable iff (srst)
    $stable(ratio_reg) && $stable(eprom_boot_strap_reg) && $stable(bms_reg))
    else $error("strap sample changed outside reset");

  rst_ind_hold_a: assert property (@(posedge clk)
    $fell(srst) |-> !reset_indication_out_n [*8])
    else $error("reset indication released too early");

  rst_ind_time_a: assert property (@(posedge clk) disable iff (srst)
    $rose(reset_indication_out_n) |-> lk.count == crrbs_pkg::LOCK_CYCLES)
    else $error("reset indication released at wrong time");

  bms_float_a: assert property (@(posedge clk) disable iff (srst)
    !boot_memory_select_oe_n |-> boot_mode == crrbs_pkg::CRRBS_BOOT_EPROM)
    else $error("boot select driven outside EPROM mode");

  serial_chan_a: assert property (@(posedge clk) disable iff (srst)
    (boot_mode == crrbs_pkg::CRRBS_BOOT_SPI) |-> boot_dma_channel == crrbs_pkg::DMA_CH_SERIAL)
    else $error("serial boot not on channel 8");

  host_chan_a: assert property (@(posedge clk) disable iff (srst)
    (boot_mode == crrbs_pkg::CRRBS_BOOT_HOST) |-> boot_dma_channel == crrbs_pkg::DMA_CH_EXTPRT)
    else $error("host boot not on channel 10");

  cov_release_c: cover property (@(posedge clk) $rose(reset_indication_out_n));
  cov_eprom_c:   cover property (@(posedge clk) !boot_memory_select_oe_n);
  cov_dbl_c:     cover property (@(posedge clk) port_clock_double && !port_clock_output_oe_n);

endmodule

// File: dv/crrbs_board_model.sv
// Board straps and boot select wire as seen by the strap controller
`timescale 1ns/1ps
module crrbs_board_model (
  input  wire logic       clk,       // Input clock
  input  wire logic       srst,      // Device reset
  input  wire logic       rogue,     // Lets straps move outside reset
  input  wire logic [8:0] want,      // {id, bms, link_boot_strap, eprom_boot_strap, ratio, dbl}
  input  wire logic       bms_out,   // Device boot select drive
  input  wire logic       bms_oe_n,  // Low while device drives select
  output logic      [8:0] pins,      // Strap pin levels
  output logic            bms_wire   // Boot select wire level
);
  // ==========================================================================
  // Straps
  // straps hardwired, moved only in reset or while rogue is high
  always_ff @(posedge clk) begin
    if (srst || rogue) begin
      pins <= want;
    end
  end

  // ==========================================================================
  // Boot select wire
  // device drives wire only when enabled
  assign bms_wire = bms_oe_n ? pins[5] : bms_out;
endmodule

// File: dv/crrbs_strap_ctrl_tb.sv
// Self-checking bench for the strap controller
`timescale 1ns/1ps
module crrbs_strap_ctrl_tb;
  logic        clk, srst, rogue, bm, hg_n, es, bms_wire;
  logic [8:0]  want, pins;
  logic [3:0]  mult, ch;
  logic [5:0]  mode;
  logic [23:0] faddr;
  logic        rr, dblo, pco, pco_oe_n, keep, rst_n, fetch, brs, bms_o, bms_oe_n;
  int          n_errors, cmp_count, cyc, t, seed;
  logic        prev;

  crrbs_board_model u_crrbs_board_model (.clk(clk), .srst(srst), .rogue(rogue), .want(want),
    .bms_out(bms_o), .bms_oe_n(bms_oe_n), .pins(pins), .bms_wire(bms_wire));

  crrbs_strap_ctrl u_crrbs_strap_ctrl (.clk(clk), .srst(srst), .clock_double_select(pins[0]),
    .core_ratio_select(pins[2:1]), .eprom_boot_strap(pins[3]), .link_boot_strap(pins[4]),
    .processor_identity_strap(pins[8:6]), .bus_master(bm), .host_bus_grant_n(hg_n),
    .boot_memory_select_in(bms_wire), .eprom_select(es), .core_multiplier(mult),
    .ratio_reserved(rr), .port_clock_double(dblo), .port_clock_output(pco),
    .port_clock_output_oe_n(pco_oe_n), .port_clock_keeper_en(keep),
    .reset_indication_out_n(rst_n), .core_fetch_en(fetch), .fetch_address(faddr),
    .boot_mode(mode), .boot_dma_channel(ch), .boot_reserved(brs),
    .boot_memory_select_out(bms_o), .boot_memory_select_oe_n(bms_oe_n));

  // ==========================================================================
  // Clock, steady 50 ns period
  // input clock never stops
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Cycle ceiling against hangs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      end_sim();
    end
  end

  // ==========================================================================
  // Expectations
  function automatic logic [3:0] exp_mult(logic d, logic [1:0] r);
    if (r == 2'h3) return 4'h0;
    return d ? 4'(r + 2) : 4'((r + 2) * 2);
  endfunction

  function automatic logic [5:0] exp_mode(logic e, logic l, logic b);
    if (e && l) return 6'h20;
    if (e) return 6'h01;
    if (l) return b ? 6'h08 : 6'h04;
    return b ? 6'h02 : 6'h10;
  endfunction

  task automatic chk(string name, logic [23:0] seen, logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Reset with new straps, then check the decode
  task automatic do_reset(logic [8:0] w);
    logic [5:0] m;
    @(posedge clk) begin
      srst <= 1'h1;
      want <= w;
      bm   <= 1'h0;
      hg_n <= 1'h1;
    end
    repeat (10) @(posedge clk);
    srst <= 1'h0;
    repeat (3) @(posedge clk);
    #1;
    m = exp_mode(w[3], w[4], w[5]);
    chk("mult", mult, exp_mult(w[0], w[2:1]));
    chk("ratio_rsvd", rr, w[2:1] == 2'h3);
    chk("double", dblo, !w[0]);
    chk("keeper", keep, w[8:7] == 2'h0);
    chk("mode", mode, m);
    chk("chan", ch, (m == 6'h01 || m == 6'h02) ? 4'hA : (m[3:2] != 0) ? 4'h8 : 4'h0);
    chk("boot_rsvd", brs, m == 6'h20);
    chk("fetch_addr", faddr, 24'h000000);
  endtask

  // Own the bus, count port clock toggles, then hand over to the host
  task automatic bus_test(logic d, logic [5:0] m);
    @(posedge clk) bm <= 1'h1;
    repeat (5) @(posedge clk);
    #1;
    chk("pclk_oe", pco_oe_n, 1'h0);
    chk("bms_oe", bms_oe_n, m != 6'h01);
    t = 0;
    prev = pco;
    repeat (8) begin
      @(posedge clk);
      #1;
      if (pco !== prev) t++;
      prev = pco;
    end
    chk("pclk_toggles", t, d ? 4 : 8);
    // Boot select follows the loader request one cycle late
    if (m == 6'h01) begin
      repeat (6) begin
        @(posedge clk) es <= 1'($random(seed));
        @(posedge clk);
        #1;
        chk("bms_out", bms_o, !es);
      end
    end
    @(posedge clk) hg_n <= 1'h0;
    repeat (4) @(posedge clk);
    #1;
    chk("pclk_oe_host", pco_oe_n, 1'h1);
    chk("bms_oe_host", bms_oe_n, 1'h1);
    t = 0;
    prev = pco;
    repeat (4) begin
      @(posedge clk);
      #1;
      if (pco !== prev) t++;
      prev = pco;
    end
    chk("pclk_idle", t, 0);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    logic [8:0] w;
    seed = 38;
    n_errors = 0;
    cmp_count = 0;
    cyc = 0;
    srst = 1'h1;
    rogue = 1'h0;
    bm = 1'h0;
    hg_n = 1'h1;
    es = 1'h0;
    want = 9'h000;
    repeat (10) @(posedge clk);
    #1;
    chk("rst_ind_in_reset", rst_n, 1'h0);
    // Every strap and boot select level combination, random identity
    for (int i = 0; i < 64; i++) begin
      w = {3'($random(seed)), 6'(i)};
      do_reset(w);
      bus_test(w[0], exp_mode(w[3], w[4], w[5]));
    end
    // Straps moved outside reset must not change the decode
    w = 9'h009;
    do_reset(w);
    @(posedge clk) begin
      rogue <= 1'h1;
      want  <= 9'h1F6;
    end
    repeat (5) @(posedge clk);
    #1;
    chk("mult_hold", mult, 4'h2);
    chk("mode_hold", mode, 6'h01);
    @(posedge clk) rogue <= 1'h0;
    // Reset indication timing after release
    @(posedge clk) srst <= 1'h1;
    repeat (10) @(posedge clk);
    srst <= 1'h0;
    repeat (4079) @(posedge clk);
    #1;
    chk("rst_ind_early", rst_n, 1'h0);
    chk("fetch_early", fetch, 1'h0);
    @(posedge clk);
    #1;
    chk("rst_ind_lock", rst_n, 1'h1);
    chk("fetch_lock", fetch, 1'h1);
    end_sim();
  end
endmodule
